// File: include/tx_queue_pkg.sv
/*
 * Shared constants and carrier types for the transmit event FIFO
 * status logic and the transmit queue control register.
 * Assumes a single 25 MHz clock domain and a word-wide register port.
 */
package tx_queue_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_OFFSET     = 8'h00;
   localparam logic [7:0] USER_ADDR_OFFSET  = 8'h04;
   localparam logic [7:0] QUEUE_CTRL_OFFSET = 8'h08;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int OVERFLOW_BIT    = 3;
   localparam int FULL_BIT        = 2;
   localparam int HALF_BIT        = 1;
   localparam int NONEMPTY_BIT    = 0;
   localparam int STATUS_USED     = 4;
   localparam int PAYLOAD_LSB     = 29;
   localparam int DEPTH_LSB       = 24;
   localparam int ATTEMPTS_LSB    = 21;
   localparam int PRIORITY_LSB    = 16;
   localparam int RESET_BIT       = 10;
   localparam int REQUEST_BIT     = 9;
   localparam int INCREMENT_BIT   = 8;
   localparam int DIRECTION_BIT   = 7;
   localparam int ATT_IE_BIT      = 4;
   localparam int EMPTY_IE_BIT    = 2;
   localparam int NOTFULL_IE_BIT  = 0;

   // ----------------------------------------------------------------
   // widths, reset values, address layout
   // ----------------------------------------------------------------
   localparam int PTR_W = 5;
   localparam int CNT_W = 6;
   localparam logic [1:0]  ATTEMPTS_RESET = 2'h3;
   localparam logic        QRESET_RESET   = 1'b1;
   // base and object stride of the event area in message RAM
   localparam logic [31:0] EVENT_RAM_BASE  = 32'h0000_0400;
   localparam logic [31:0] EVENT_OBJ_BYTES = 32'h0000_000C;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed {
      logic [2:0] payload;
      logic [4:0] depth;
      logic [1:0] attempts;
      logic [4:0] rank;
   } queue_cfg_t;

endpackage : tx_queue_pkg

// File: rtl/event_fifo_tracker.sv
/*
 * Occupancy, tail index and overflow tracking of the transmit event
 * FIFO. Assumes push and pop come from logic on the same clock.
 */
module event_fifo_tracker (
   input  wire logic                      ref_clk_in,
   input  wire logic                      reset_n_in,
   input  wire logic                      push_in,
   input  wire logic                      pop_in,
   input  wire logic [4:0]                depth_field_in,
   input  wire logic                      clear_overflow_in,
   output logic [tx_queue_pkg::CNT_W-1:0] count_out,
   output logic [tx_queue_pkg::PTR_W-1:0] tail_out,
   output logic                           overflow_out
);

   typedef struct packed {
      logic [tx_queue_pkg::CNT_W-1:0] count;
      logic [tx_queue_pkg::PTR_W-1:0] tail;
      logic                           overflow;
   } track_t;

   track_t track_reg;
   track_t track_next;

   always_comb begin
      logic [tx_queue_pkg::CNT_W-1:0] cap;
      logic                           do_pop;
      logic                           do_push;
      cap        = {1'b0, depth_field_in} + 6'h01;
      do_pop     = pop_in && (track_reg.count != 6'h00);
      do_push    = push_in && ((track_reg.count < cap) || do_pop);
      track_next = track_reg;
      if (do_pop) begin
         if (track_reg.tail == depth_field_in) begin
            track_next.tail = 5'h00;
         end else begin
            track_next.tail = track_reg.tail + 5'h01;
         end
      end
      track_next.count = track_reg.count + {5'h00, do_push}
                       - {5'h00, do_pop};
      // a new overflow in the clearing cycle stays visible
      if (clear_overflow_in) begin
         track_next.overflow = 1'b0;
      end
      if (push_in && !do_push) begin
         track_next.overflow = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         track_reg <= '0;
      end else begin
         track_reg <= track_next;
      end
   end

   assign count_out    = track_reg.count;
   assign tail_out     = track_reg.tail;
   assign overflow_out = track_reg.overflow;

endmodule : event_fifo_tracker

// File: rtl/tx_event_fifo_and_tx_queue_ctrl.sv
/*
 * Event FIFO status/address registers and transmit queue control.
 * Assumes a register port with one-cycle strobes and a protocol engine
 * on the same clock that reports sent, aborted and exhausted messages.
 */
// Decided for this implementation: the register offsets and the address-and-strobe port.
// Summary of operation
// - overflow flag sets on a push without pop into a full event FIFO, held until the host writes zero
// - full flag is one exactly when occupancy equals the depth field plus one
// - half flag is one when twice the occupancy is at least the depth field plus one
// - not-empty flag is one while any event object is stored
// - full, half and not-empty flags are live and ignore writes
// - user address read returns RAM address of the FIFO tail
// - payload and depth fields change only in configuration mode
// - queue reset bit resets the queue, then clears; zero ignored
// - reset bit held set in configuration mode, clears in normal
// - send request starts sending, clears when queue drains
// - writing zero while request set asks for abort
// - send request updates on completion, abort or queue reset
// - head increment advances queue head by exactly one slot unless the queue is full or in queue reset
// - direction bit always reads one
// - attempts-exhausted interrupt passes only when enabled
// - queue-empty interrupt passes only when enabled
// - queue-not-full interrupt passes only when enabled
// - unimplemented bits read as zero
module tx_event_fifo_and_tx_queue_ctrl (
   input  wire logic                      ref_clk_in,
   input  wire logic                      reset_n_in,
   input  wire tx_queue_pkg::reg_req_t    reg_req_in,
   input  wire logic                      config_mode_in,
   input  wire logic                      event_push_in,
   input  wire logic                      event_pop_in,
   input  wire logic [4:0]                event_depth_in,
   input  wire logic                      msg_sent_in,
   input  wire logic                      msg_aborted_in,
   input  wire logic                      attempts_exhausted_in,
   output logic [31:0]                    rd_data_out,
   output tx_queue_pkg::queue_cfg_t       queue_cfg_out,
   output logic                           tx_request_out,
   output logic                           abort_request_out,
   output logic [tx_queue_pkg::CNT_W-1:0] queue_count_out,
   output logic [tx_queue_pkg::PTR_W-1:0] queue_head_out,
   output logic                           attempts_irq_out,
   output logic                           empty_irq_out,
   output logic                           notfull_irq_out
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0]                    rd_data;
      tx_queue_pkg::queue_cfg_t       cfg;
      logic                           qreset;
      logic                           send_req;
      logic                           abort_req;
      logic                           ie_att;
      logic                           ie_empty;
      logic                           ie_notfull;
      logic                           att_pending;
      logic [tx_queue_pkg::PTR_W-1:0] head;
      logic [tx_queue_pkg::PTR_W-1:0] tail;
      logic [tx_queue_pkg::CNT_W-1:0] count;
      logic                           irq_att;
      logic                           irq_empty;
      logic                           irq_notfull;
   } ctrl_t;

   ctrl_t ctrl_reg;
   ctrl_t ctrl_next;

   logic [tx_queue_pkg::CNT_W-1:0] ev_count;
   logic [tx_queue_pkg::PTR_W-1:0] ev_tail;
   logic                           ev_overflow;
   logic [tx_queue_pkg::CNT_W-1:0] ev_cap;
   logic                           ev_full;
   logic                           ev_half;
   logic                           ev_nonempty;
   logic [31:0]                    ev_addr;
   logic [tx_queue_pkg::CNT_W-1:0] q_cap;
   logic                           wr_status;
   logic                           wr_ctrl;
   logic                           clear_ovf;

   // ----------------------------------------------------------------
   // event FIFO status
   // ----------------------------------------------------------------
   assign wr_status = reg_req_in.wr
                   && (reg_req_in.addr == tx_queue_pkg::STATUS_OFFSET);
   assign wr_ctrl   = reg_req_in.wr
                   && (reg_req_in.addr == tx_queue_pkg::QUEUE_CTRL_OFFSET);
   // only the overflow bit is host clearable; the others are live
   assign clear_ovf = wr_status
                   && !reg_req_in.wdata[tx_queue_pkg::OVERFLOW_BIT];

   event_fifo_tracker event_fifo_tracker_i (
      .ref_clk_in        (ref_clk_in),
      .reset_n_in        (reset_n_in),
      .push_in           (event_push_in),
      .pop_in            (event_pop_in),
      .depth_field_in    (event_depth_in),
      .clear_overflow_in (clear_ovf),
      .count_out         (ev_count),
      .tail_out          (ev_tail),
      .overflow_out      (ev_overflow)
   );

   assign ev_cap      = {1'b0, event_depth_in} + 6'h01;
   assign ev_full     = (ev_count == ev_cap);
   assign ev_half     = ({ev_count, 1'b0} >= {1'b0, ev_cap});
   assign ev_nonempty = (ev_count != 6'h00);
   // tail index scaled to a byte address in message RAM
   assign ev_addr     = tx_queue_pkg::EVENT_RAM_BASE
                      + 32'(ev_tail) * tx_queue_pkg::EVENT_OBJ_BYTES;

   // queue capacity is the depth field plus one
   assign q_cap = {1'b0, ctrl_reg.cfg.depth} + 6'h01;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] status_word;
      logic [31:0] ctrl_word;
      logic        sent_ok;
      logic        inc_ok;
      logic [tx_queue_pkg::CNT_W-1:0] cap_next;
      sent_ok     = 1'b0;
      inc_ok      = 1'b0;
      cap_next    = '0;
      status_word = '0;
      ctrl_word   = '0;
      status_word[tx_queue_pkg::OVERFLOW_BIT] = ev_overflow;
      status_word[tx_queue_pkg::FULL_BIT]     = ev_full;
      status_word[tx_queue_pkg::HALF_BIT]     = ev_half;
      status_word[tx_queue_pkg::NONEMPTY_BIT] = ev_nonempty;
      ctrl_word[tx_queue_pkg::PAYLOAD_LSB +: 3]  = ctrl_reg.cfg.payload;
      ctrl_word[tx_queue_pkg::DEPTH_LSB +: 5]    = ctrl_reg.cfg.depth;
      ctrl_word[tx_queue_pkg::ATTEMPTS_LSB +: 2] = ctrl_reg.cfg.attempts;
      ctrl_word[tx_queue_pkg::PRIORITY_LSB +: 5] = ctrl_reg.cfg.rank;
      ctrl_word[tx_queue_pkg::RESET_BIT]      = ctrl_reg.qreset;
      ctrl_word[tx_queue_pkg::REQUEST_BIT]    = ctrl_reg.send_req;
      ctrl_word[tx_queue_pkg::DIRECTION_BIT]  = 1'b1;
      ctrl_word[tx_queue_pkg::ATT_IE_BIT]     = ctrl_reg.ie_att;
      ctrl_word[tx_queue_pkg::EMPTY_IE_BIT]   = ctrl_reg.ie_empty;
      ctrl_word[tx_queue_pkg::NOTFULL_IE_BIT] = ctrl_reg.ie_notfull;

      ctrl_next           = ctrl_reg;
      ctrl_next.abort_req = 1'b0;
      sent_ok = msg_sent_in && (ctrl_reg.count != 6'h00);
      inc_ok  = wr_ctrl && reg_req_in.wdata[tx_queue_pkg::INCREMENT_BIT]
             && (ctrl_reg.count < q_cap);

      // engine reports: hardware clears come before host sets
      if (sent_ok) begin
         if (ctrl_reg.tail == ctrl_reg.cfg.depth) begin
            ctrl_next.tail = 5'h00;
         end else begin
            ctrl_next.tail = ctrl_reg.tail + 5'h01;
         end
         if (ctrl_reg.count == 6'h01) begin
            ctrl_next.send_req = 1'b0;
         end
      end
      if (msg_aborted_in) begin
         ctrl_next.send_req = 1'b0;
      end
      if (inc_ok) begin
         if (ctrl_reg.head == ctrl_reg.cfg.depth) begin
            ctrl_next.head = 5'h00;
         end else begin
            ctrl_next.head = ctrl_reg.head + 5'h01;
         end
      end
      ctrl_next.count = ctrl_reg.count + {5'h00, inc_ok}
                      - {5'h00, sent_ok};

      // queue reset: held in configuration, one cycle in normal mode
      if (config_mode_in || ctrl_reg.qreset) begin
         ctrl_next.head        = '0;
         ctrl_next.tail        = '0;
         ctrl_next.count       = '0;
         ctrl_next.send_req    = 1'b0;
         ctrl_next.att_pending = 1'b0;
         ctrl_next.qreset      = config_mode_in;
      end

      // host writes; a set here wins over any clear above
      if (wr_ctrl) begin
         if (config_mode_in) begin
            ctrl_next.cfg.payload =
               reg_req_in.wdata[tx_queue_pkg::PAYLOAD_LSB +: 3];
            ctrl_next.cfg.depth   =
               reg_req_in.wdata[tx_queue_pkg::DEPTH_LSB +: 5];
         end
         ctrl_next.cfg.attempts =
            reg_req_in.wdata[tx_queue_pkg::ATTEMPTS_LSB +: 2];
         ctrl_next.cfg.rank =
            reg_req_in.wdata[tx_queue_pkg::PRIORITY_LSB +: 5];
         ctrl_next.ie_att     = reg_req_in.wdata[tx_queue_pkg::ATT_IE_BIT];
         ctrl_next.ie_empty   =
            reg_req_in.wdata[tx_queue_pkg::EMPTY_IE_BIT];
         ctrl_next.ie_notfull =
            reg_req_in.wdata[tx_queue_pkg::NOTFULL_IE_BIT];
         if (reg_req_in.wdata[tx_queue_pkg::RESET_BIT]) begin
            ctrl_next.qreset = 1'b1;
         end
         if (reg_req_in.wdata[tx_queue_pkg::REQUEST_BIT]) begin
            ctrl_next.send_req    = 1'b1;
            ctrl_next.att_pending = 1'b0;
         end else if (ctrl_reg.send_req) begin
            // bit stays set until the engine reports the abort
            ctrl_next.abort_req = 1'b1;
         end
      end

      // a new exhaustion outranks a same-cycle clear, so none is lost
      if (attempts_exhausted_in) begin
         ctrl_next.att_pending = 1'b1;
      end

      // read data stand for one cycle only
      ctrl_next.rd_data = '0;
      if (reg_req_in.rd) begin
         if (reg_req_in.addr == tx_queue_pkg::STATUS_OFFSET) begin
            ctrl_next.rd_data = status_word;
         end else if (reg_req_in.addr
                      == tx_queue_pkg::USER_ADDR_OFFSET) begin
            ctrl_next.rd_data = ev_addr;
         end else if (reg_req_in.addr
                      == tx_queue_pkg::QUEUE_CTRL_OFFSET) begin
            ctrl_next.rd_data = ctrl_word;
         end
      end

      // masked interrupt levels follow the next state
      cap_next = {1'b0, ctrl_next.cfg.depth} + 6'h01;
      ctrl_next.irq_att     = ctrl_next.ie_att
                           && ctrl_next.att_pending;
      ctrl_next.irq_empty   = ctrl_next.ie_empty
                           && (ctrl_next.count == 6'h00);
      ctrl_next.irq_notfull = ctrl_next.ie_notfull
                           && (ctrl_next.count < cap_next);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ctrl_reg              <= '0;
         ctrl_reg.cfg.attempts <= tx_queue_pkg::ATTEMPTS_RESET;
         ctrl_reg.qreset       <= tx_queue_pkg::QRESET_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   assign rd_data_out       = ctrl_reg.rd_data;
   assign queue_cfg_out     = ctrl_reg.cfg;
   assign tx_request_out    = ctrl_reg.send_req;
   assign abort_request_out = ctrl_reg.abort_req;
   assign queue_count_out   = ctrl_reg.count;
   assign queue_head_out    = ctrl_reg.head;
   assign attempts_irq_out  = ctrl_reg.irq_att;
   assign empty_irq_out     = ctrl_reg.irq_empty;
   assign notfull_irq_out   = ctrl_reg.irq_notfull;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   overflow_set_a: assert property (
      event_push_in && ev_full && !event_pop_in
      |=> ev_overflow)
      else $error("overflow flag not set on push into full fifo");

   full_flag_a: assert property (
      reg_req_in.rd && reg_req_in.addr == tx_queue_pkg::STATUS_OFFSET
      |=> rd_data_out[tx_queue_pkg::FULL_BIT]
          == ($past(ev_count) == $past(ev_cap)))
      else $error("full flag does not match occupancy");

   half_flag_a: assert property (
      reg_req_in.rd && reg_req_in.addr == tx_queue_pkg::STATUS_OFFSET
      && ev_count == 6'h00
      |=> !rd_data_out[tx_queue_pkg::HALF_BIT])
      else $error("half flag set on empty fifo");

   nonempty_flag_a: assert property (
      reg_req_in.rd && reg_req_in.addr == tx_queue_pkg::STATUS_OFFSET
      |=> rd_data_out[tx_queue_pkg::NONEMPTY_BIT]
          == ($past(ev_count) != 6'h00))
      else $error("not-empty flag does not match occupancy");

   user_addr_a: assert property (
      reg_req_in.rd && reg_req_in.addr == tx_queue_pkg::USER_ADDR_OFFSET
      |=> rd_data_out == $past(ev_addr))
      else $error("user address read is not the fifo tail address");

   cfg_locked_a: assert property (
      !config_mode_in
      |=> $stable(queue_cfg_out.payload) && $stable(queue_cfg_out.depth))
      else $error("payload or depth changed outside configuration");

   qreset_hold_a: assert property (
      config_mode_in |=> ctrl_reg.qreset && queue_count_out == 6'h00)
      else $error("queue reset not held in configuration mode");

   qreset_done_a: assert property (
      !config_mode_in && ctrl_reg.qreset && !wr_ctrl
      |=> !ctrl_reg.qreset && !tx_request_out
          ##1 (!ctrl_reg.qreset || $past(config_mode_in) || $past(wr_ctrl)))
      else $error("queue reset bit did not clear after the reset");

   head_step_a: assert property (
      wr_ctrl && reg_req_in.wdata[tx_queue_pkg::INCREMENT_BIT]
      && !config_mode_in && !ctrl_reg.qreset && !msg_sent_in
      && queue_count_out < q_cap
      |=> queue_count_out == $past(queue_count_out) + 6'h01)
      else $error("head increment did not add exactly one message");

   abort_req_a: assert property (
      wr_ctrl && !reg_req_in.wdata[tx_queue_pkg::REQUEST_BIT]
      && tx_request_out
      |=> abort_request_out ##1 (!abort_request_out || $past(wr_ctrl)))
      else $error("abort not requested for a cleared send request");

   drain_clear_a: assert property (
      msg_sent_in && queue_count_out == 6'h01 && !wr_ctrl
      |=> !tx_request_out)
      else $error("send request not cleared after last message");

   direction_one_a: assert property (
      reg_req_in.rd && reg_req_in.addr == tx_queue_pkg::QUEUE_CTRL_OFFSET
      |=> rd_data_out[tx_queue_pkg::DIRECTION_BIT]
          && rd_data_out[15:11] == 5'h00)
      else $error("direction bit or reserved bits read wrong");

   att_irq_mask_a: assert property (
      attempts_irq_out == (ctrl_reg.ie_att && ctrl_reg.att_pending))
      else $error("attempts interrupt does not follow its enable");

   empty_irq_mask_a: assert property (
      empty_irq_out == (ctrl_reg.ie_empty && queue_count_out == 6'h00))
      else $error("empty interrupt does not follow its enable");

   notfull_irq_mask_a: assert property (
      notfull_irq_out == (ctrl_reg.ie_notfull && queue_count_out < q_cap))
      else $error("not-full interrupt does not follow its enable");

endmodule : tx_event_fifo_and_tx_queue_ctrl

// File: tb/engine_model.sv
/* Behavioural protocol engine: sends queued messages, answers aborts.
   Assumes the clock and reset of the block under test. */
module engine_model (
   input  wire logic                             ref_clk_in,
   input  wire logic                             reset_n_in,
   input  wire logic                             send_en_in,
   input  wire logic                             tx_request_in,
   input  wire logic                             abort_request_in,
   input  wire logic [tx_queue_pkg::CNT_W-1:0]   count_in,
   output logic                                  msg_sent_out,
   output logic                                  msg_aborted_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // one message every other cycle, so the count settles before the next
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         msg_sent_out    <= 1'b0;
         msg_aborted_out <= 1'b0;
      end else begin
         msg_sent_out    <= send_en_in && tx_request_in && !msg_sent_out
                            && count_in != '0;
         msg_aborted_out <= abort_request_in;
      end
   end
endmodule : engine_model

// File: tb/tx_event_fifo_and_tx_queue_ctrl_test.sv
/* Register-level bench of the event FIFO status and queue control.
   Assumes the engine model answers send and abort requests. */
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
   mismatches++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tx_event_fifo_and_tx_queue_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] ST = tx_queue_pkg::STATUS_OFFSET;
   localparam logic [7:0] UA = tx_queue_pkg::USER_ADDR_OFFSET;
   localparam logic [7:0] CT = tx_queue_pkg::QUEUE_CTRL_OFFSET;
   logic                           clk, rst_n, cfg_mode, push, pop;
   logic                           exhaust, send_en, sent, aborted;
   logic                           tx_req, abort_req, att_irq, e_irq, nf_irq;
   logic [4:0]                     ev_depth;
   logic [31:0]                    rd_data, rv;
   logic [tx_queue_pkg::CNT_W-1:0] q_count;
   logic [tx_queue_pkg::PTR_W-1:0] q_head;
   tx_queue_pkg::reg_req_t         req;
   tx_queue_pkg::queue_cfg_t       cfg;
   int                             mismatches, checks_done;

   tx_event_fifo_and_tx_queue_ctrl tx_event_fifo_and_tx_queue_ctrl_i (
      .ref_clk_in(clk), .reset_n_in(rst_n), .reg_req_in(req),
      .config_mode_in(cfg_mode), .event_push_in(push), .event_pop_in(pop),
      .event_depth_in(ev_depth), .msg_sent_in(sent),
      .msg_aborted_in(aborted), .attempts_exhausted_in(exhaust),
      .rd_data_out(rd_data), .queue_cfg_out(cfg), .tx_request_out(tx_req),
      .abort_request_out(abort_req), .queue_count_out(q_count),
      .queue_head_out(q_head), .attempts_irq_out(att_irq),
      .empty_irq_out(e_irq), .notfull_irq_out(nf_irq));
   engine_model engine_model_i (
      .ref_clk_in(clk), .reset_n_in(rst_n), .send_en_in(send_en),
      .tx_request_in(tx_req), .abort_request_in(abort_req),
      .count_in(q_count), .msg_sent_out(sent), .msg_aborted_out(aborted));

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      #1 rv = rd_data;
   endtask : rd
   task automatic ev(input logic p, input logic q, input int n);
      repeat (n) begin
         @(posedge clk);
         push <= p;
         pop  <= q;
         @(posedge clk);
         push <= 1'b0;
         pop  <= 1'b0;
      end
   endtask : ev
   // the queue may not be touched until its reset bit reads back clear
   task automatic poll_reset();
      for (int i = 0; i < 20; i++) begin
         rd(CT);
         if (rv[tx_queue_pkg::RESET_BIT] === 1'b0) break;
      end
   endtask : poll_reset
   task automatic wait_idle();
      for (int i = 0; i < 50 && tx_req !== 1'b0; i++) @(posedge clk);
      #1;
   endtask : wait_idle
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #200000;
      mismatches++;
      end_sim();
   end
   initial begin
      {rst_n, push, pop, exhaust, send_en} = '0;
      cfg_mode = 1'b1;
      ev_depth = 5'h03;
      req      = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd(CT); `CHK(rv, 32'h0060_0480)
      wr(CT, 32'hA17F_0015);
      rd(CT); `CHK(rv, 32'hA17F_0495)
      `CHK(cfg, {3'h5, 5'h01, 2'h3, 5'h1F})
      @(posedge clk);
      cfg_mode <= 1'b0;
      poll_reset();
      `CHK(rv, 32'hA17F_0095)
      wr(CT, 32'h0060_0015);
      rd(CT); `CHK(rv, 32'hA160_0095)
      $display("test configuration done");
      wr(CT, 32'h0060_0115);
      #1 `CHK(q_head, 5'h01)
      repeat (2) wr(CT, 32'h0060_0115);
      @(posedge clk);
      #1 `CHK(q_count, 6'h02)
      `CHK(q_head, 5'h00)
      `CHK(nf_irq, 1'b0)
      send_en <= 1'b1;
      wr(CT, 32'h0060_0215);
      #1 `CHK(tx_req, 1'b1)
      wait_idle();
      `CHK(q_count, 6'h00)
      `CHK({e_irq, nf_irq}, 2'b11)
      $display("test send done");
      send_en <= 1'b0;
      wr(CT, 32'h0060_0115);
      wr(CT, 32'h0060_0215);
      wr(CT, 32'h0060_0015);
      #1 `CHK({abort_req, tx_req}, 2'b11)
      wait_idle();
      `CHK(tx_req, 1'b0)
      wr(CT, 32'h0060_0415);
      poll_reset();
      `CHK(q_count, 6'h00)
      @(posedge clk);
      exhaust <= 1'b1;
      @(posedge clk);
      exhaust <= 1'b0;
      repeat (2) @(posedge clk);
      #1 `CHK(att_irq, 1'b1)
      wr(CT, 32'h0060_0000);
      @(posedge clk);
      #1 `CHK({att_irq, e_irq, nf_irq}, 3'b000)
      $display("test abort and interrupts done");
      ev(1'b1, 1'b0, 4);
      rd(ST); `CHK(rv, 32'h0000_0007)
      rd(UA); `CHK(rv, 32'h0000_0400)
      ev(1'b1, 1'b0, 1);
      rd(ST); `CHK(rv, 32'h0000_000F)
      wr(ST, 32'hFFFF_FFF7);
      rd(ST); `CHK(rv, 32'h0000_0007)
      ev(1'b0, 1'b1, 1);
      rd(ST); `CHK(rv, 32'h0000_0003)
      rd(UA); `CHK(rv, 32'h0000_040C)
      ev(1'b0, 1'b1, 2);
      rd(ST); `CHK(rv, 32'h0000_0001)
      ev(1'b0, 1'b1, 1);
      rd(ST); `CHK(rv, 32'h0000_0000)
      rd(8'h0C); `CHK(rv, 32'h0000_0000)
      $display("test event fifo done");
      end_sim();
   end
endmodule : tx_event_fifo_and_tx_queue_ctrl_test
